/* File: src/dcs_consts.svh */
// timing figures and derived cycle counts for the command spacer
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

`define DCS_CLK_PERIOD_PS 10000

// round a least time up to whole cycles, never below the cycle minimum
`define DCS_CYC_UP(ps) (((ps) + `DCS_CLK_PERIOD_PS - 1) / `DCS_CLK_PERIOD_PS)
`define DCS_MAX_GAP(n, ps) (((n) > `DCS_CYC_UP(ps)) ? (n) : `DCS_CYC_UP(ps))

`define DCS_COL_SAME_GROUP_CYC 5
`define DCS_COL_SAME_GROUP_PS 5355
`define DCS_COL_OTHER_GROUP_CYC 4

`define DCS_ACT_OTHER_2K_CYC 4
`define DCS_ACT_OTHER_2K_PS 5300
`define DCS_ACT_OTHER_1K_CYC 4
`define DCS_ACT_OTHER_1K_PS 3700
`define DCS_ACT_SAME_2K_CYC 4
`define DCS_ACT_SAME_2K_PS 6400
`define DCS_ACT_SAME_1K_CYC 4
`define DCS_ACT_SAME_1K_PS 5300

`define DCS_FAW_2K_CYC 28
`define DCS_FAW_2K_PS 30000
`define DCS_FAW_1K_CYC 20
`define DCS_FAW_1K_PS 21000
`define DCS_FAW_HALF_CYC 16
`define DCS_FAW_HALF_PS 15000

`define DCS_WTR_OTHER_CYC 2
`define DCS_WTR_OTHER_PS 2500
`define DCS_WTR_SAME_CYC 4
`define DCS_WTR_SAME_PS 7500
`define DCS_RTP_CYC 4
`define DCS_RTP_PS 7500

`define DCS_FAW_DEPTH 4
`define DCS_GROUPS 4
`define DCS_BANKS_PER_GROUP 4

`endif

/* File: src/dcs_pkg.sv */
// types shared by the command spacer
package dcs_pkg;
  typedef enum logic [2:0] {
    DCS_CMD_NOP = 3'b000,
    DCS_CMD_ACT = 3'b001,
    DCS_CMD_RD  = 3'b010,
    DCS_CMD_WR  = 3'b011,
    DCS_CMD_PRE = 3'b100
  } dcs_cmd_t;

  typedef enum logic [0:0] {
    DCS_ST_IDLE = 1'b0,
    DCS_ST_HOLD = 1'b1
  } dcs_state_t;
endpackage

/* File: src/dcs_age_bank.sv */
// bank of saturating cycle-age counters, restarted per entry
`timescale 1ns/1ns
`default_nettype none
module dcs_age_bank
  import dcs_pkg::*;
#(
  parameter int N  = 4,
  parameter int AW = 8
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic [N-1:0]          restart_i,
  output var  logic [N-1:0][AW-1:0]  age_o
);
  typedef struct packed {
    logic [N-1:0][AW-1:0] age;
  } dcs_age_st_t;

  dcs_age_st_t st;
  dcs_age_st_t next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      if (restart_i[i]) begin
        next_st.age[i] = AW'(1);
      end else if (st.age[i] != {AW{1'b1}}) begin
        next_st.age[i] = st.age[i] + AW'(1);
      end
    end
  end

  // saturated at reset: nothing has happened yet, so nothing blocks
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '{age: {N{{AW{1'b1}}}}};
    end else begin
      st <= next_st;
    end
  end

  assign age_o = st.age;
endmodule
`default_nettype wire

/* File: src/dcs_spacer.sv */
// host-side command spacer holding dram commands until all gaps are met
// How it works
// - same-group column commands: max(5 cycles, 5.355ns)
// - other-group column commands: 4 cycles apart
// - 2KB page, other-group activates: max(4, 5.3ns)
// - smaller page, other-group activates: max(4, 3.7ns)
// - 2KB page, same-group activates: max(4, 6.4ns)
// - smaller page, same-group activates: max(4, 5.3ns)
// - 2KB page: four activates per max(28, 30ns)
// - 1KB page: four activates per max(20, 21ns)
// - half page: four activates per max(16, 15ns)
// - write start to read: per-group write-to-read gaps
// - read to same-bank precharge: max(4, 7.5ns)
`timescale 1ns/1ns
`default_nettype none
`include "dcs_consts.svh"
module dcs_spacer
  import dcs_pkg::*;
#(
  parameter int AW             = 8,
  parameter int GW             = 2,
  parameter int BW             = 2,
  parameter int WRITE_START_LAT = 10
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic          wide_part_i,
  input  wire logic          half_page_i,
  input  wire logic          cmd_valid_i,
  input  wire dcs_cmd_t      cmd_kind_i,
  input  wire logic [GW-1:0] cmd_group_i,
  input  wire logic [BW-1:0] cmd_bank_i,
  output var  logic          cmd_ready_o,
  output var  logic          dram_valid_o,
  output var  dcs_cmd_t      dram_cmd_o,
  output var  logic [GW-1:0] dram_group_o,
  output var  logic [BW-1:0] dram_bank_o
);
  localparam int NG = `DCS_GROUPS;
  localparam int NB = `DCS_GROUPS * `DCS_BANKS_PER_GROUP;
  localparam int FD = `DCS_FAW_DEPTH;

  // gap counts in cycles; each time is rounded up first
  localparam logic [AW-1:0] COL_SAME_GAP  =
    AW'(`DCS_MAX_GAP(`DCS_COL_SAME_GROUP_CYC, `DCS_COL_SAME_GROUP_PS));
  localparam logic [AW-1:0] COL_OTHER_GAP = AW'(`DCS_COL_OTHER_GROUP_CYC);
  localparam logic [AW-1:0] ACT_OTHER_2K  = AW'(`DCS_MAX_GAP(`DCS_ACT_OTHER_2K_CYC, `DCS_ACT_OTHER_2K_PS));
  localparam logic [AW-1:0] ACT_OTHER_1K  = AW'(`DCS_MAX_GAP(`DCS_ACT_OTHER_1K_CYC, `DCS_ACT_OTHER_1K_PS));
  localparam logic [AW-1:0] ACT_SAME_2K   = AW'(`DCS_MAX_GAP(`DCS_ACT_SAME_2K_CYC, `DCS_ACT_SAME_2K_PS));
  localparam logic [AW-1:0] ACT_SAME_1K   = AW'(`DCS_MAX_GAP(`DCS_ACT_SAME_1K_CYC, `DCS_ACT_SAME_1K_PS));
  localparam logic [AW-1:0] FAW_2K        = AW'(`DCS_MAX_GAP(`DCS_FAW_2K_CYC, `DCS_FAW_2K_PS));
  localparam logic [AW-1:0] FAW_1K        = AW'(`DCS_MAX_GAP(`DCS_FAW_1K_CYC, `DCS_FAW_1K_PS));
  localparam logic [AW-1:0] FAW_HALF      = AW'(`DCS_MAX_GAP(`DCS_FAW_HALF_CYC, `DCS_FAW_HALF_PS));
  // write gaps count from the write command plus the lead to the internal start
  localparam logic [AW-1:0] WTR_OTHER_GAP =
    AW'(`DCS_MAX_GAP(`DCS_WTR_OTHER_CYC, `DCS_WTR_OTHER_PS) + WRITE_START_LAT);
  localparam logic [AW-1:0] WTR_SAME_GAP  =
    AW'(`DCS_MAX_GAP(`DCS_WTR_SAME_CYC, `DCS_WTR_SAME_PS) + WRITE_START_LAT);
  localparam logic [AW-1:0] RTP_GAP       = AW'(`DCS_MAX_GAP(`DCS_RTP_CYC, `DCS_RTP_PS));

  typedef struct packed {
    dcs_state_t           state;
    dcs_cmd_t             kind;
    logic [GW-1:0]        group;
    logic [BW-1:0]        bank;
    logic                 ready;
    logic                 out_valid;
    dcs_cmd_t             out_cmd;
    logic [GW-1:0]        out_group;
    logic [BW-1:0]        out_bank;
    logic [FD-1:0][AW-1:0] faw_age;
  } dcs_state_st_t;

  dcs_state_st_t st;
  dcs_state_st_t next_st;

  logic [NG-1:0][AW-1:0] col_age;
  logic [NG-1:0][AW-1:0] act_age;
  logic [NG-1:0][AW-1:0] wr_age;
  logic [NB-1:0][AW-1:0] rd_age;
  logic [NG-1:0]         col_restart;
  logic [NG-1:0]         act_restart;
  logic [NG-1:0]         wr_restart;
  logic [NB-1:0]         rd_restart;
  logic                  issue;

  function automatic logic [3:0] bank_index(input logic [GW-1:0] g, input logic [BW-1:0] b);
    bank_index = {g, b};
  endfunction

  function automatic logic gap_met(input logic [AW-1:0] age, input logic [AW-1:0] gap);
    gap_met = (age >= gap);
  endfunction

  // page-size column chosen from the part width; half page is an explicit option
  logic [AW-1:0] act_other_gap;
  logic [AW-1:0] act_same_gap;
  logic [AW-1:0] faw_gap;
  always_comb begin
    act_other_gap = wide_part_i ? ACT_OTHER_2K : ACT_OTHER_1K;
    act_same_gap  = wide_part_i ? ACT_SAME_2K : ACT_SAME_1K;
    if (wide_part_i) begin
      faw_gap = FAW_2K;
    end else if (half_page_i) begin
      faw_gap = FAW_HALF;
    end else begin
      faw_gap = FAW_1K;
    end
  end

  // decide whether the held command may go out this cycle
  logic allowed;
  always_comb begin
    allowed = 1'b1;
    case (st.kind)
      DCS_CMD_RD, DCS_CMD_WR: begin
        for (int h = 0; h < NG; h++) begin
          if (GW'(h) == st.group) begin
            if (!gap_met(col_age[h], COL_SAME_GAP)) allowed = 1'b0;
          end else begin
            if (!gap_met(col_age[h], COL_OTHER_GAP)) allowed = 1'b0;
          end
          if (st.kind == DCS_CMD_RD) begin
            if (GW'(h) == st.group) begin
              if (!gap_met(wr_age[h], WTR_SAME_GAP)) allowed = 1'b0;
            end else begin
              if (!gap_met(wr_age[h], WTR_OTHER_GAP)) allowed = 1'b0;
            end
          end
        end
      end
      DCS_CMD_ACT: begin
        for (int h = 0; h < NG; h++) begin
          if (GW'(h) == st.group) begin
            if (!gap_met(act_age[h], act_same_gap)) allowed = 1'b0;
          end else begin
            if (!gap_met(act_age[h], act_other_gap)) allowed = 1'b0;
          end
        end
        // oldest of the last four activates must have left the window
        if (!gap_met(st.faw_age[FD-1], faw_gap)) allowed = 1'b0;
      end
      DCS_CMD_PRE: begin
        if (!gap_met(rd_age[bank_index(st.group, st.bank)], RTP_GAP)) allowed = 1'b0;
      end
      default: allowed = 1'b1;
    endcase
  end

  assign issue = (st.state == DCS_ST_HOLD) && allowed;

  always_comb begin
    col_restart = '0;
    act_restart = '0;
    wr_restart  = '0;
    rd_restart  = '0;
    if (issue) begin
      case (st.kind)
        DCS_CMD_RD: begin
          col_restart[st.group] = 1'b1;
          rd_restart[bank_index(st.group, st.bank)] = 1'b1;
        end
        DCS_CMD_WR: begin
          col_restart[st.group] = 1'b1;
          wr_restart[st.group]  = 1'b1;
        end
        DCS_CMD_ACT: act_restart[st.group] = 1'b1;
        default: col_restart = '0;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.out_valid = 1'b0;
    next_st.out_cmd   = DCS_CMD_NOP;
    for (int i = 0; i < FD; i++) begin
      if (st.faw_age[i] != {AW{1'b1}}) next_st.faw_age[i] = st.faw_age[i] + AW'(1);
    end
    case (st.state)
      DCS_ST_IDLE: begin
        if (cmd_valid_i && st.ready) begin
          next_st.state = DCS_ST_HOLD;
          next_st.kind  = cmd_kind_i;
          next_st.group = cmd_group_i;
          next_st.bank  = cmd_bank_i;
          next_st.ready = 1'b0;
        end
      end
      DCS_ST_HOLD: begin
        if (issue) begin
          next_st.state     = DCS_ST_IDLE;
          next_st.ready     = 1'b1;
          next_st.out_valid = 1'b1;
          next_st.out_cmd   = st.kind;
          next_st.out_group = st.group;
          next_st.out_bank  = st.bank;
          if (st.kind == DCS_CMD_ACT) begin
            for (int i = FD - 1; i > 0; i--) begin
              next_st.faw_age[i] = next_st.faw_age[i-1];
            end
            next_st.faw_age[0] = AW'(1);
          end
        end
      end
      default: next_st.state = DCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '{state: DCS_ST_IDLE, kind: DCS_CMD_NOP, group: '0, bank: '0, ready: 1'b1,
              out_valid: 1'b0, out_cmd: DCS_CMD_NOP, out_group: '0, out_bank: '0,
              faw_age: {FD{{AW{1'b1}}}}};
    end else begin
      st <= next_st;
    end
  end

  // per-group and per-bank history kept in four separate counter banks
  dcs_age_bank #(.N(NG), .AW(AW)) u_col_age (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .restart_i  (col_restart),
    .age_o      (col_age)
  );
  dcs_age_bank #(.N(NG), .AW(AW)) u_act_age (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .restart_i  (act_restart),
    .age_o      (act_age)
  );
  dcs_age_bank #(.N(NG), .AW(AW)) u_wr_age (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .restart_i  (wr_restart),
    .age_o      (wr_age)
  );
  dcs_age_bank #(.N(NB), .AW(AW)) u_rd_age (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .restart_i  (rd_restart),
    .age_o      (rd_age)
  );

  assign cmd_ready_o  = st.ready;
  assign dram_valid_o = st.out_valid;
  assign dram_cmd_o   = st.out_cmd;
  assign dram_group_o = st.out_group;
  assign dram_bank_o  = st.out_bank;
endmodule
`default_nettype wire

/* File: sim/dcs_spacer_properties.sv */
// concurrent checks on the command spacer ports
`timescale 1ns/1ns
`default_nettype none
module dcs_spacer_properties
  import dcs_pkg::*;
#(
  parameter int GW              = 2,
  parameter int BW              = 2,
  parameter int WRITE_START_LAT = 10
) (
  input wire logic          core_clk_i,
  input wire logic          reset_i,
  input wire logic          wide_part_i,
  input wire logic          half_page_i,
  input wire logic          cmd_valid_i,
  input wire dcs_cmd_t      cmd_kind_i,
  input wire logic [GW-1:0] cmd_group_i,
  input wire logic [BW-1:0] cmd_bank_i,
  input wire logic          cmd_ready_o,
  input wire logic          dram_valid_o,
  input wire dcs_cmd_t      dram_cmd_o,
  input wire logic [GW-1:0] dram_group_o,
  input wire logic [BW-1:0] dram_bank_o
);
  // ages count cycles since the last column, activate, write and read pulse
  logic [7:0]       c_age, a_age, w_age, r_age;
  logic [GW-1:0]    c_g, w_g;
  logic [GW+BW-1:0] r_gb;
  logic [3:0][7:0]  f_age;
  wire logic rd  = dram_valid_o && dram_cmd_o == DCS_CMD_RD;
  wire logic wr  = dram_valid_o && dram_cmd_o == DCS_CMD_WR;
  wire logic act = dram_valid_o && dram_cmd_o == DCS_CMD_ACT;
  wire logic pre = dram_valid_o && dram_cmd_o == DCS_CMD_PRE;
  wire logic col = rd || wr;

  function automatic logic [7:0] nx(logic hit, logic [7:0] a);
    return hit ? 8'h01 : (a == 8'hff ? a : a + 8'h01);
  endfunction

  // only the latest event is kept, but the last four for activates: weaker than full history, never false
  always_ff @(posedge core_clk_i) begin
    c_age <= reset_i ? 8'hff : nx(col, c_age);
    a_age <= reset_i ? 8'hff : nx(act, a_age);
    w_age <= reset_i ? 8'hff : nx(wr, w_age);
    r_age <= reset_i ? 8'hff : nx(rd, r_age);
    if (col) c_g <= dram_group_o;
    if (wr) w_g <= dram_group_o;
    if (rd) r_gb <= {dram_group_o, dram_bank_o};
    // ages of the last four activates, newest first
    f_age[0] <= reset_i ? 8'hff : nx(act, f_age[0]);
    for (int i = 1; i < 4; i++) f_age[i] <= reset_i ? 8'hff : nx(1'b0, act ? f_age[i-1] : f_age[i]);
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_take; cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !dram_valid_o; endproperty
  a_take: assert property (p_take) else $error("ready or issue too early after take");
  property p_ans; cmd_valid_i && cmd_ready_o |-> ##[2:40] dram_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("taken command never issued");
  property p_pulse; dram_valid_o |=> !dram_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("issue pulse longer than a cycle");
  property p_ready; dram_valid_o |-> cmd_ready_o; endproperty
  a_ready: assert property (p_ready) else $error("ready not back with issue");
  property p_nop; !dram_valid_o |-> dram_cmd_o == DCS_CMD_NOP; endproperty
  a_nop: assert property (p_nop) else $error("command shown while not valid");
  property p_col_s; col && dram_group_o == c_g |-> c_age >= 5; endproperty
  a_col_s: assert property (p_col_s) else $error("same group column gap short");
  property p_col_o; col |-> c_age >= 4; endproperty
  a_col_o: assert property (p_col_o) else $error("column gap short");
  property p_act; act |-> a_age >= 4; endproperty
  a_act: assert property (p_act) else $error("activate gap short");
  property p_wtr_s; rd && dram_group_o == w_g |-> w_age >= 4 + WRITE_START_LAT; endproperty
  a_wtr_s: assert property (p_wtr_s) else $error("same group write to read short");
  property p_wtr_o; rd |-> w_age >= 2 + WRITE_START_LAT; endproperty
  a_wtr_o: assert property (p_wtr_o) else $error("write to read short");
  property p_rtp; pre && {dram_group_o, dram_bank_o} == r_gb |-> r_age >= 4; endproperty
  a_rtp: assert property (p_rtp) else $error("read to precharge short");
  property p_faw; act |-> f_age[3] >= (wide_part_i ? 28 : (half_page_i ? 16 : 20)); endproperty
  a_faw: assert property (p_faw) else $error("fifth activate inside window");
endmodule

bind dcs_spacer dcs_spacer_properties #(.GW(GW), .BW(BW), .WRITE_START_LAT(WRITE_START_LAT)) i_props (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .wide_part_i(wide_part_i), .half_page_i(half_page_i),
  .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_group_i(cmd_group_i), .cmd_bank_i(cmd_bank_i),
  .cmd_ready_o(cmd_ready_o), .dram_valid_o(dram_valid_o), .dram_cmd_o(dram_cmd_o),
  .dram_group_o(dram_group_o), .dram_bank_o(dram_bank_o));
`default_nettype wire

/* File: sim/dcs_dram_model.sv */
// memory-side model counting command spacing violations
`timescale 1ns/1ns
`default_nettype none
module dcs_dram_model
  import dcs_pkg::*;
#(
  parameter int WSL = 10
) (
  input wire logic       core_clk_i,
  input wire logic       dram_valid_i,
  input wire dcs_cmd_t   dram_cmd_i,
  input wire logic [1:0] dram_group_i,
  input wire logic [1:0] dram_bank_i,
  input wire logic       wide_part_i,
  input wire logic       half_page_i,
  output var int         viol_o
);
  // every time rounds below its cycle minimum at 10 ns, so cycle minimums
  int t = 0, lcany = -999, laany = -999, lwany = -999, nviol = 0;
  int lc[4] = '{default: -999};
  int la[4] = '{default: -999};
  int lw[4] = '{default: -999};
  int lr[16] = '{default: -999};
  int aq[$];
  assign viol_o = nviol;
  function automatic void need(int ago, int gap);
    if (t - ago < gap) nviol++;
  endfunction
  always @(posedge core_clk_i) begin
    t++;
    if (dram_valid_i === 1'b1) begin
      case (dram_cmd_i)
        DCS_CMD_RD, DCS_CMD_WR: begin
          need(lc[dram_group_i], 5);
          need(lcany, 4);
          if (dram_cmd_i == DCS_CMD_RD) begin
            need(lw[dram_group_i], 4 + WSL);
            need(lwany, 2 + WSL);
            lr[{dram_group_i, dram_bank_i}] = t;
          end else begin
            lw[dram_group_i] = t;
            lwany = t;
          end
          lc[dram_group_i] = t;
          lcany = t;
        end
        DCS_CMD_ACT: begin
          need(la[dram_group_i], 4);
          need(laany, 4);
          if (aq.size() == 4) need(aq.pop_front(), wide_part_i ? 28 : half_page_i ? 16 : 20);
          aq.push_back(t);
          la[dram_group_i] = t;
          laany = t;
        end
        DCS_CMD_PRE: need(lr[{dram_group_i, dram_bank_i}], 4);
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: sim/ddr4_command_spacing_checker_tb.sv */
// self-checking bench for the command spacer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: got %0d want %0d", $time, a, b); end end
module ddr4_command_spacing_checker_tb;
  import dcs_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wide = 1'b1, half = 1'b0, valid = 1'b0, rdy, dvld;
  dcs_cmd_t   kind = DCS_CMD_NOP, dcmd, last;
  logic [1:0] grp = 2'h0, bnk = 2'h0, dgrp, dbnk;
  logic [3:0] lgb;
  int         n_errors = 0, samples_checked = 0, cyc = 0, viol;
  int         ts[$];
  always #5 clk = ~clk;
  dcs_spacer i_dut (.core_clk_i(clk), .reset_i(rst), .wide_part_i(wide), .half_page_i(half),
    .cmd_valid_i(valid), .cmd_kind_i(kind), .cmd_group_i(grp), .cmd_bank_i(bnk), .cmd_ready_o(rdy),
    .dram_valid_o(dvld), .dram_cmd_o(dcmd), .dram_group_o(dgrp), .dram_bank_o(dbnk));
  dcs_dram_model i_mem (.core_clk_i(clk), .dram_valid_i(dvld), .dram_cmd_i(dcmd), .dram_group_i(dgrp),
    .dram_bank_i(dbnk), .wide_part_i(wide), .half_page_i(half), .viol_o(viol));
  // ceiling well above the roughly 800 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (dvld === 1'b1) begin
      ts.push_back(cyc);
      last = dcmd;
      lgb = {dgrp, dbnk};
    end
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request held until the edge that sees ready high
  task automatic send(dcs_cmd_t k, logic [1:0] g, logic [1:0] b);
    @(negedge clk);
    valid = 1'b1;
    kind = k;
    grp = g;
    bnk = b;
    do @(posedge clk); while (rdy !== 1'b1);
    @(negedge clk);
    valid = 1'b0;
  endtask
  // idle long enough that no earlier history still blocks
  task automatic settle(int n);
    while (ts.size() < n) @(negedge clk);
    repeat (40) @(negedge clk);
  endtask
  task automatic pair(dcs_cmd_t k1, dcs_cmd_t k2, logic [1:0] g2, logic [1:0] b2, int exp);
    int n;
    n = ts.size();
    send(k1, 2'h0, 2'h1);
    send(k2, g2, b2);
    settle(n + 2);
    `CHK(ts[n+1] - ts[n], exp)
    `CHK(last, k2)
    `CHK(lgb, {g2, b2})
  endtask
  task automatic faw(logic w, logic h, int exp);
    int n;
    wide = w;
    half = h;
    n = ts.size();
    for (int i = 0; i < 5; i++) send(DCS_CMD_ACT, i[1:0], 2'h2);
    settle(n + 5);
    `CHK(ts[n+4] - ts[n], exp)
  endtask
  task automatic t_col();
    pair(DCS_CMD_RD, DCS_CMD_RD, 2'h0, 2'h0, 5);
    pair(DCS_CMD_WR, DCS_CMD_WR, 2'h0, 2'h3, 5);
    pair(DCS_CMD_RD, DCS_CMD_WR, 2'h1, 2'h0, 4);
    $display("test col done");
  endtask
  task automatic t_act();
    pair(DCS_CMD_ACT, DCS_CMD_ACT, 2'h0, 2'h2, 4);
    pair(DCS_CMD_ACT, DCS_CMD_ACT, 2'h1, 2'h0, 4);
    wide = 1'b0;
    pair(DCS_CMD_ACT, DCS_CMD_ACT, 2'h0, 2'h2, 4);
    pair(DCS_CMD_ACT, DCS_CMD_ACT, 2'h2, 2'h0, 4);
    $display("test act done");
  endtask
  task automatic t_wtr();
    pair(DCS_CMD_WR, DCS_CMD_RD, 2'h0, 2'h1, 14);
    pair(DCS_CMD_WR, DCS_CMD_RD, 2'h3, 2'h0, 12);
    $display("test wtr done");
  endtask
  task automatic t_rtp();
    pair(DCS_CMD_RD, DCS_CMD_PRE, 2'h0, 2'h1, 4);
    pair(DCS_CMD_RD, DCS_CMD_PRE, 2'h1, 2'h1, 2);
    pair(DCS_CMD_RD, DCS_CMD_NOP, 2'h2, 2'h3, 2);
    $display("test rtp done");
  endtask
  task automatic t_faw();
    faw(1'b1, 1'b0, 28);
    faw(1'b0, 1'b0, 20);
    faw(1'b0, 1'b1, 16);
    $display("test faw done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    `CHK(rdy, 1'b1)
    `CHK(dvld, 1'b0)
    `CHK(dcmd, DCS_CMD_NOP)
    t_col();
    t_act();
    t_wtr();
    t_rtp();
    t_faw();
    `CHK(viol, 0)
    complete_run();
  end
endmodule
`default_nettype wire
